/* File: design/wwd_cnt_if.sv */
// Interface: control and status between the watchdog top and its counter.
// Assumes both ends sit on the same clock.
interface wwd_cnt_if;
  import wwd_pkg::*;
  logic                  tick;
  logic                  clr;
  logic                  run;
  logic                  pre_sel;
  logic [POST_SEL_W-1:0] post_sel;
  logic                  timeout;
  logic                  early;
  logic [ELAPSED_W-1:0]  elapsed;

  modport ctl (output tick, clr, run, pre_sel, post_sel, input timeout, early, elapsed);
  modport cnt (input tick, clr, run, pre_sel, post_sel, output timeout, early, elapsed);
endinterface : wwd_cnt_if

/* File: design/wwd_counter.sv */
// Prescaler and postscaler counter of the watchdog.
// Assumes tick is a one-cycle pulse per RC oscillator period.
module wwd_counter (
  input wire logic clk,
  input wire logic rst,
  wwd_cnt_if.cnt   cif
);
  import wwd_pkg::*;

  logic [PRE_W-1:0]     pre_ff;
  logic [POST_W-1:0]    post_ff;
  logic                 timeout_ff;
  logic [PRE_W-1:0]     nxt_pre;
  logic [POST_W-1:0]    nxt_post;

  // ==========================================================================
  // Ratio selection
  wire [PRE_W-1:0]  pre_last  = cif.pre_sel ? PRE_LAST_128 : PRE_LAST_32;
  wire [2:0]        pre_shift = cif.pre_sel ? PRE_SHIFT_128 : PRE_SHIFT_32;
  wire [POST_W-1:0] post_last = POST_W'((32'd1 << cif.post_sel) - 32'd1);
  wire              step      = cif.tick && cif.run;
  wire              pre_wrap  = step && (pre_ff == pre_last);
  wire              post_wrap = pre_wrap && (post_ff == post_last);

  // ==========================================================================
  // Window position: elapsed ticks against three quarters of the period
  wire [4:0]           period_log = 5'(cif.post_sel) + 5'(pre_shift);
  wire [ELAPSED_W-1:0] win_start  = ELAPSED_W'(22'h3 << (period_log - QUARTER_SHIFT));
  wire [ELAPSED_W-1:0] elapsed_w  = (ELAPSED_W'(post_ff) << pre_shift) | ELAPSED_W'(pre_ff);

  always_comb begin
    nxt_pre  = pre_ff;
    nxt_post = post_ff;
    if (cif.clr) begin
      nxt_pre  = '0;
      nxt_post = '0;
    end else if (step) begin
      nxt_pre = pre_wrap ? '0 : PRE_W'(pre_ff + 1'b1);
      if (pre_wrap) begin
        nxt_post = post_wrap ? '0 : POST_W'(post_ff + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff     <= '0;
      post_ff    <= '0;
      timeout_ff <= 1'b0;
    end else begin
      pre_ff     <= nxt_pre;
      post_ff    <= nxt_post;
      timeout_ff <= post_wrap && !cif.clr;
    end
  end

  assign cif.timeout = timeout_ff;
  assign cif.elapsed = elapsed_w;
  assign cif.early   = elapsed_w < win_start;

endmodule // wwd_counter

/* File: design/wwd_pkg.sv */
// Package: constants, register map and types of the windowed watchdog.
// Assumes a single 20 MHz clock domain; the RC oscillator is modelled as a tick.
package wwd_pkg;

  // ==========================================================================
  // Clocking
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RCO_HZ          = 32_000;
  localparam int unsigned RCO_DIV         = CLK_HZ / RCO_HZ;
  localparam int unsigned RCO_CNT_W       = 10;
  localparam logic [RCO_CNT_W-1:0] RCO_LAST = RCO_CNT_W'(RCO_DIV - 1);

  // Nominal base periods at the prescaler output, in microseconds
  localparam int unsigned BASE_PERIOD_DIV32_US  = 1000;
  localparam int unsigned BASE_PERIOD_DIV128_US = 4000;

  // ==========================================================================
  // Counter geometry
  localparam int unsigned PRE_W     = 7;
  localparam int unsigned POST_W    = 15;
  localparam int unsigned ELAPSED_W = PRE_W + POST_W;
  localparam int unsigned POST_SEL_W = 4;
  localparam logic [PRE_W-1:0] PRE_LAST_32  = 7'h1f;
  localparam logic [PRE_W-1:0] PRE_LAST_128 = 7'h7f;
  localparam logic [2:0] PRE_SHIFT_32  = 3'h5;
  localparam logic [2:0] PRE_SHIFT_128 = 3'h7;
  localparam logic [4:0] QUARTER_SHIFT = 5'h02;

  // ==========================================================================
  // APB register map (byte addresses)
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CTL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG    = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h008;

  // reset_control_reg fields
  localparam int unsigned RC_SOFT_EN_BIT = 5;
  localparam int unsigned RC_TIMEOUT_BIT = 4;
  localparam int unsigned RC_SLEEP_BIT   = 3;
  localparam int unsigned RC_IDLE_BIT    = 2;

  // wd_config_word fields
  localparam int unsigned CFG_W          = 8;
  localparam int unsigned CFG_HARD_EN_BIT = 7;
  localparam int unsigned CFG_WIN_OFF_BIT = 6;
  localparam int unsigned CFG_PRE_BIT     = 4;
  localparam int unsigned CFG_POST_LSB    = 0;
  localparam logic [CFG_W-1:0] CFG_RESET  = 8'hdf;
  localparam logic [CFG_W-1:0] CFG_MASK   = 8'hdf;

  // Status register fields
  localparam int unsigned ST_PWR_LSB = 22;

  // ==========================================================================
  // Power state
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_IDLE  = 2'b10
  } wwd_pwr_t;

endpackage : wwd_pkg

/* File: design/wwd_top.sv */
// Windowed watchdog timer with APB register access.
// Assumes core instruction strobes are one-cycle pulses synchronous to clk.
//
// Contract
// - Watchdog runs from RC oscillator, enable forces it
// - Prescaler divides by 32 or 128
// - Base period 1 ms or 4 ms
// - Postscaler has sixteen ratios 1:1 to 1:32768
// - Any device reset clears all counts
// - Completed clock switch clears all counts
// - Entering sleep or idle clears counts
// - Leaving sleep or idle clears counts
// - Clear instruction clears counts while running
// - Counts in sleep/idle; timeout wakes the core
// - Sleep/idle flags stay until software clears
// - Hard enable forces watchdog on
// - Otherwise soft enable bit controls it
// - Any device reset clears soft enable
// - Window mode: early clear causes reset
// - Timeout flag sticky, cleared only by software
// - Prescale select one means divide by 128
// - Postscale code n gives ratio two to n
// - Window-off bit one means non-window mode
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module wwd_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [wwd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output wire logic [31:0]               prdata,
  output wire logic                      pready,
  output wire logic                      pslverr,
  input  wire logic                      sys_reset,
  input  wire logic                      clear_watchdog_instr,
  input  wire logic                      power_save_instr,
  input  wire logic                      power_save_idle,
  input  wire logic                      osc_switch_done,
  input  wire logic                      wake_event,
  output wire logic                      low_power_rc_osc_on,
  output wire logic                      wd_reset_req,
  output wire logic                      wd_wake,
  output wire logic                      core_halted
);
  import wwd_pkg::*;

  wwd_cnt_if cif ();

  logic [CFG_W-1:0]      cfg_ff;
  logic                  soft_en_ff;
  localparam int unsigned FLAG_N = RC_TIMEOUT_BIT - RC_IDLE_BIT + 1;
  logic [FLAG_N-1:0]     flag_ff;
  wwd_pwr_t              pwr_ff;
  wwd_pwr_t              nxt_pwr;
  logic [RCO_CNT_W-1:0]  rco_cnt_ff;
  logic                  tick_ff;
  logic                  osc_on_ff;
  logic                  reset_req_ff;
  logic                  wake_ff;
  logic                  halted_ff;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;

  // ==========================================================================
  // Configuration decode
  wire wd_hard_enable      = cfg_ff[CFG_HARD_EN_BIT];
  wire wd_window_off       = cfg_ff[CFG_WIN_OFF_BIT];
  wire wd_prescale_select  = cfg_ff[CFG_PRE_BIT];
  wire [POST_SEL_W-1:0] wd_postscale_select = cfg_ff[CFG_POST_LSB +: POST_SEL_W];
  wire wd_enabled  = wd_hard_enable || soft_en_ff;
  wire window_mode = !wd_window_off;

  // ==========================================================================
  // Event decode
  wire running     = (pwr_ff == PWR_RUN);
  wire clr_run     = clear_watchdog_instr && running;
  wire psave_run   = power_save_instr && running;
  wire timeout_evt = cif.timeout;
  wire leave_save  = !running && (timeout_evt || wake_event);
  wire early_clear = clr_run && wd_enabled && window_mode && cif.early;
  wire bite        = (timeout_evt && running) || early_clear;
  wire count_clr   = sys_reset || osc_switch_done || psave_run
                  || leave_save || clr_run || !wd_enabled;

  assign cif.tick     = tick_ff;
  assign cif.run      = wd_enabled;
  assign cif.clr      = count_clr;
  assign cif.pre_sel  = wd_prescale_select;
  assign cif.post_sel = wd_postscale_select;

  wwd_counter u_counter (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // ==========================================================================
  // RC oscillator tick: only runs while the watchdog holds the oscillator on
  wire rco_wrap = (rco_cnt_ff == RCO_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_on_ff  <= 1'b0;
      rco_cnt_ff <= '0;
      tick_ff    <= 1'b0;
    end else begin
      osc_on_ff  <= wd_enabled;
      rco_cnt_ff <= (!osc_on_ff || rco_wrap) ? '0 : RCO_CNT_W'(rco_cnt_ff + 1'b1);
      tick_ff    <= osc_on_ff && rco_wrap;
    end
  end

  // ==========================================================================
  // Power state
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_RUN: begin
        if (psave_run) begin
          nxt_pwr = power_save_idle ? PWR_IDLE : PWR_SLEEP;
        end
      end
      PWR_SLEEP,
      PWR_IDLE: begin
        if (leave_save) begin
          nxt_pwr = PWR_RUN;
        end
      end
      default: nxt_pwr = PWR_RUN;
    endcase
    if (sys_reset) begin
      nxt_pwr = PWR_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_ff       <= PWR_RUN;
      reset_req_ff <= 1'b0;
      wake_ff      <= 1'b0;
      halted_ff    <= 1'b0;
    end else begin
      pwr_ff       <= nxt_pwr;
      reset_req_ff <= bite;
      wake_ff      <= leave_save && timeout_evt;
      halted_ff    <= (nxt_pwr != PWR_RUN);
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, pready answers in the access phase
  wire setup_ph  = psel && !penable;
  wire access_ok = psel && penable && pready_ff;
  wire wr_done   = access_ok && pwrite && !pslverr_ff;
  wire hit_rc    = (paddr == ADDR_RESET_CTL);
  wire hit_cfg   = (paddr == ADDR_CONFIG);
  wire hit_st    = (paddr == ADDR_STATUS);
  wire mapped    = hit_rc || hit_cfg || hit_st;
  wire wr_rc     = wr_done && hit_rc;
  wire wr_cfg    = wr_done && hit_cfg;

  wire [31:0] rc_rd  = (32'(soft_en_ff) << RC_SOFT_EN_BIT)
                     | (32'(flag_ff) << RC_IDLE_BIT);
  wire [31:0] cfg_rd = 32'(cfg_ff);
  wire [31:0] st_rd  = (32'(pwr_ff) << ST_PWR_LSB) | 32'(cif.elapsed);
  wire [31:0] rd_mux = hit_rc ? rc_rd : hit_cfg ? cfg_rd : hit_st ? st_rd : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph && !mapped;
      if (setup_ph) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================================
  // Registers. Writing zero clears a flag; a hardware set in the same cycle wins.
  // Flag i sits at reset_control_reg bit RC_IDLE_BIT + i: idle, sleep, then timeout
  wire              set_sleep = psave_run && !power_save_idle;
  wire              set_idle  = psave_run && power_save_idle;
  wire [FLAG_N-1:0] flag_set  = {timeout_evt || early_clear, set_sleep, set_idle};
  wire [FLAG_N-1:0] nxt_flag;

  for (genvar gi = 0; gi < FLAG_N; gi++) begin : g_flag
    wire clr_flag = wr_rc && !pwdata[RC_IDLE_BIT + gi];
    assign nxt_flag[gi] = flag_set[gi] || (flag_ff[gi] && !clr_flag);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff     <= CFG_RESET;
      soft_en_ff <= 1'b0;
      flag_ff    <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= pwdata[CFG_W-1:0] & CFG_MASK;
      end
      if (sys_reset) begin
        soft_en_ff <= 1'b0;
      end else if (wr_rc) begin
        soft_en_ff <= pwdata[RC_SOFT_EN_BIT];
      end
      flag_ff <= nxt_flag;
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign low_power_rc_osc_on = osc_on_ff;
  assign wd_reset_req        = reset_req_ff;
  assign wd_wake             = wake_ff;
  assign core_halted         = halted_ff;

endmodule // wwd_top

/* File: tb/tb_windowed_watchdog_timer.sv */
// Testbench: APB, core model and resets; checks timeouts, enables and flags.
// Assumes the design shortest period, div32 and postscale 1:1, for speed.
module tb_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import wwd_pkg::*;
  logic              clk, rst, psel, penable, pwrite, sys_reset, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              clr_i, ps_i, ps_idle, osw, wake, rc_on, bite, wwake, halted;
  int                miscompares, compares, seed, k;

  wwd_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_reset(sys_reset), .clear_watchdog_instr(clr_i), .power_save_instr(ps_i),
    .power_save_idle(ps_idle), .osc_switch_done(osw), .wake_event(wake),
    .low_power_rc_osc_on(rc_on), .wd_reset_req(bite), .wd_wake(wwake), .core_halted(halted));
  wwd_core_model core_u (.clk(clk), .clear_watchdog_instr(clr_i), .power_save_instr(ps_i),
    .power_save_idle(ps_idle), .osc_switch_done(osw), .wake_event(wake));

  // ==========================================================================
  // Helpers
  function automatic int period(input int div, input int post);
    int base_us;
    base_us = (div == 32) ? BASE_PERIOD_DIV32_US : BASE_PERIOD_DIV128_US;
    return (base_us * (CLK_HZ / 1_000_000)) << post;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Starts one edge late so a release and the next setup never share a step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 1, n);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sysrst;
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
  endtask

  // Tick phase is free running, so allow one tick either side
  task automatic wait_evt(input string what, input int t);
    int n;
    n = 0;
    while (bite !== 1'b1 && wwake !== 1'b1 && n <= t + RCO_DIV + 8) begin
      @(posedge clk);
      n++;
    end
    chk(what, 1, (n + int'(RCO_DIV) >= t) && (n <= t + RCO_DIV + 8));
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    seed = 32'he0eae300;
    {rst, psel, penable, pwrite, sys_reset} = 5'h10;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("osc on", 1, rc_on);
    apb(0, ADDR_CONFIG, 0);
    chk("config", 32'hdf, rd);
    apb(0, ADDR_RESET_CTL, 0);
    chk("reset ctl", 0, rd);
    apb(0, 12'h00c, 0);
    chk("unmapped err", 1, er);
    apb(1, ADDR_CONFIG, 32'h40);
    repeat (2) @(posedge clk);
    chk("osc soft off", 0, rc_on);
    apb(1, ADDR_RESET_CTL, 32'h20);
    repeat (2) @(posedge clk);
    chk("osc soft on", 1, rc_on);
    sysrst;
    repeat (2) @(posedge clk);
    chk("soft cleared", 0, rc_on);
    apb(1, ADDR_RESET_CTL, 32'h20);
    wait_evt("div32 timeout", period(32, 0));
    chk("bite", 1, bite);
    apb(0, ADDR_RESET_CTL, 0);
    chk("flag set", 32'h30, rd);
    sysrst;
    apb(0, ADDR_RESET_CTL, 0);
    chk("flag kept", 32'h10, rd);
    apb(1, ADDR_RESET_CTL, 0);
    apb(0, ADDR_RESET_CTL, 0);
    chk("flag cleared", 0, rd);
    apb(1, ADDR_CONFIG, 32'hc0);
    repeat (1000 + ($random(seed) & 32'hfff)) @(posedge clk);
    core_u.issue(($random(seed) & 1) * 3);
    wait_evt("after clear", period(32, 0));
    sysrst;
    k = 1 + ($random(seed) & 1);
    core_u.issue(k);
    @(posedge clk);
    chk("halted", 1, halted);
    wait_evt("wake", period(32, 0));
    chk("wake pulse", 1, wwake);
    apb(0, ADDR_RESET_CTL, 0);
    chk("power flags", (k == 1) ? 32'h18 : 32'h14, rd);
    apb(1, ADDR_CONFIG, 32'h80);
    repeat (1000) @(posedge clk);
    core_u.issue(0);
    wait_evt("early clear", 0);
    sysrst;
    repeat (16000) @(posedge clk);
    core_u.issue(0);
    k = 0;
    repeat (3000) begin
      @(posedge clk);
      k = k | (bite === 1'b1);
    end
    chk("late clear", 0, k);
    core_u.issue(1);
    @(posedge clk);
    chk("asleep", 1, halted);
    core_u.issue(4);
    @(posedge clk);
    chk("wake event", 0, halted);
    chk("no wd wake", 0, wwake);
    tally_and_finish;
  end
endmodule // tb_windowed_watchdog_timer

/* File: tb/wwd_chk.sv */
// Checker: port-level watchdog and APB properties.
// Assumes one clock domain and the async reset rst.
module wwd_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_reset,
  input wire logic clear_watchdog_instr,
  input wire logic power_save_instr,
  input wire logic osc_switch_done,
  input wire logic wake_event,
  input wire logic wd_reset_req,
  input wire logic wd_wake,
  input wire logic core_halted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Assertions
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_bite_single: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request too long");
  a_bite_running: assert property (wd_reset_req |-> !$past(core_halted))
    else $error("reset request while halted");
  a_wake_halted: assert property (wd_wake |-> $past(core_halted) && !core_halted)
    else $error("wake without halt");
  a_halt_entry: assert property (power_save_instr && !core_halted && !sys_reset |=>
    core_halted) else $error("power save did not halt");
  a_clear_quiet: assert property (clear_watchdog_instr && !core_halted |->
    ##3 !wd_reset_req [*8]) else $error("timeout right after clear");
  a_switch_quiet: assert property (osc_switch_done |->
    ##3 (!wd_reset_req && !wd_wake) [*8]) else $error("timeout right after switch");
  a_halt_release: assert property ($fell(core_halted) |->
    wd_wake || $past(wake_event) || $past(sys_reset)) else $error("halt left early");

  c_bite: cover property (wd_reset_req);
  c_wake: cover property (wd_wake);
  c_err: cover property (pslverr);
endmodule // wwd_chk

bind wwd_top wwd_chk chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sys_reset(sys_reset),
  .clear_watchdog_instr(clear_watchdog_instr), .power_save_instr(power_save_instr),
  .osc_switch_done(osc_switch_done), .wake_event(wake_event),
  .wd_reset_req(wd_reset_req), .wd_wake(wd_wake), .core_halted(core_halted));

/* File: tb/wwd_core_model.sv */
// Processor core model: issues clear, power-save and clock-switch strobes.
// Assumes it shares clk with the watchdog; every strobe lasts one cycle.
module wwd_core_model (
  input  wire logic clk,
  output logic      clear_watchdog_instr,
  output logic      power_save_instr,
  output logic      power_save_idle,
  output logic      osc_switch_done,
  output logic      wake_event
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {clear_watchdog_instr, power_save_instr, osc_switch_done, wake_event} = 4'h0;
    power_save_idle = 1'b0;
  end

  // Kind 0 clear, 1 sleep, 2 idle, 3 clock switch done, 4 other wake source.
  // Window timing of clears is left to the caller, which picks the moment
  task automatic issue(input int kind);
    @(posedge clk);
    clear_watchdog_instr <= (kind == 0);
    power_save_instr     <= (kind == 1) || (kind == 2);
    power_save_idle      <= (kind == 2);
    osc_switch_done      <= (kind == 3);
    wake_event           <= (kind == 4);
    @(posedge clk);
    {clear_watchdog_instr, power_save_instr, osc_switch_done, wake_event} <= 4'h0;
  endtask
endmodule // wwd_core_model
